// ---- design/asdp_clkgen.sv ----
// half-period enable for the emitted serial clock
// assumes run is low whenever the port is idle
`timescale 1ns/1ps
module asdp_clkgen (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [7:0] half_div,
  output logic tick
);
  asdp_pkg::asdp_div_t s;
  asdp_pkg::asdp_div_t next_s;

  // ==========================================================
  // divider: one tick every half_div+1 cycles while running
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 8'h00;
    end else if (s.cnt == half_div) begin
      next_s.cnt = 8'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule // asdp_clkgen

// ---- design/asdp_serial_port.sv ----
// asynchronous serial display port: preamble, header, word or burst
// assumes configs and requests come from sys_clk logic; data in is a pin
//
// Behaviour
// - four wiring styles: 3-wire shared line, 4-wire, two 5-wire styles.
// - 5-wire type 1: select line valid around every serial clock edge.
// - 5-wire type 2: select line stable while chip select is active.
// - separate data in and out kept; output enable marks driving.
// - 4-wire uses separate input and output lines, nothing shared.
// - optional preamble, length and contents from configuration.
// - after preamble send direction and register-select bits, then data.
// - order of direction and register-select bits is configurable.
// - direction bit can be left out of the header.
// - data is one word or a burst of words.
// - each of two displays has its own configuration.
`timescale 1ns/1ps
module asdp_serial_port (
  input wire logic sys_clk,
  input wire logic srst,
  input asdp_pkg::asdp_cfg_t display_one_serial_config,
  input asdp_pkg::asdp_cfg_t display_two_serial_config,
  input wire logic req_valid,
  input asdp_pkg::asdp_req_t req,
  output logic req_ready,
  input wire logic [15:0] wr_data,
  output logic wr_next,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic done,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_enable,
  output logic serial_display_clock,
  output logic [1:0] display_chip_select,
  output logic register_select_bit
);
  typedef struct packed {
    asdp_pkg::asdp_state_t st;
    asdp_pkg::asdp_cfg_t cfg;
    asdp_pkg::asdp_req_t req;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [4:0] cnt;
    logic half;
    logic [7:0] words;
    logic cs_act;
    logic sclk;
    logic sdi_m;
    logic sdi_s;
    logic dout;
    logic oe;
    logic rs_pin;
    logic [1:0] cs_pins;
    logic sclk_pin;
    logic req_ready;
    logic wr_next;
    logic rd_valid;
    logic [15:0] rd_data;
    logic done;
  } asdp_core_t;

  asdp_core_t s;
  asdp_core_t next_s;
  logic tick;

  // ==========================================================
  // header build: {length, bits left aligned}
  function automatic logic [3:0] hdr_build(asdp_pkg::asdp_cfg_t c,
                                           asdp_pkg::asdp_req_t r);
    logic five;
    five = (c.wiring == asdp_pkg::ASDP_W5T1) ||
           (c.wiring == asdp_pkg::ASDP_W5T2);
    // five-wire styles carry the select bit on its own line
    if (c.rw_en && !five) begin
      hdr_build = c.rw_first ? {2'h2, r.read, r.rs}
                             : {2'h2, r.rs, r.read};
    end else if (c.rw_en) begin
      hdr_build = {2'h1, r.read, 1'b0};
    end else if (!five) begin
      hdr_build = {2'h1, r.rs, 1'b0};
    end else begin
      hdr_build = 4'h0;
    end
  endfunction

  function automatic logic cs_level(logic act, logic high);
    cs_level = high ? act : !act;
  endfunction

  asdp_clkgen u_clkgen (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(s.st != asdp_pkg::ST_IDLE),
    .half_div(s.cfg.half_div),
    .tick(tick)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    logic enter_pre;
    logic enter_hdr;
    logic enter_data;
    logic [3:0] h;
    enter_pre = 1'b0;
    enter_hdr = 1'b0;
    enter_data = 1'b0;
    h = 4'h0;
    next_s = s;
    next_s.sdi_m = serial_data_in;
    next_s.sdi_s = s.sdi_m;
    next_s.wr_next = 1'b0;
    next_s.rd_valid = 1'b0;
    next_s.done = 1'b0;
    case (s.st)
      asdp_pkg::ST_IDLE: begin
        if (req_valid && s.req_ready) begin
          next_s.st = asdp_pkg::ST_SETUP;
          next_s.cfg = req.disp ? display_two_serial_config
                                : display_one_serial_config;
          next_s.req = req;
          next_s.words = req.words_m1;
          next_s.rs_pin = req.rs;
        end
      end
      asdp_pkg::ST_SETUP: begin
        // one half period of select setup before chip select
        if (tick) begin
          next_s.cs_act = 1'b1;
          enter_pre = 1'b1;
        end
      end
      asdp_pkg::ST_PRE, asdp_pkg::ST_HDR, asdp_pkg::ST_DATA: begin
        if (tick && !s.half) begin
          next_s.sclk = 1'b1;
          next_s.half = 1'b1;
        end else if (tick) begin
          next_s.sclk = 1'b0;
          next_s.half = 1'b0;
          next_s.tx = {s.tx[14:0], 1'b0};
          next_s.rx = {s.rx[14:0], s.sdi_s};
          if (s.cnt != 5'h00) begin
            next_s.cnt = s.cnt - 5'h01;
          end else if (s.st == asdp_pkg::ST_PRE) begin
            enter_hdr = 1'b1;
          end else if (s.st == asdp_pkg::ST_HDR) begin
            enter_data = 1'b1;
          end else begin
            if (s.req.read) begin
              next_s.rd_valid = 1'b1;
              next_s.rd_data = next_s.rx;
            end
            if (s.words != 8'h00) begin
              next_s.words = s.words - 8'h01;
              enter_data = 1'b1;
            end else begin
              next_s.st = asdp_pkg::ST_END;
            end
          end
        end
      end
      asdp_pkg::ST_END: begin
        // hold select one half period after the last clock
        if (tick) begin
          next_s.cs_act = 1'b0;
          next_s.st = asdp_pkg::ST_IDLE;
          next_s.done = 1'b1;
        end
      end
      default: begin
        next_s.st = asdp_pkg::ST_IDLE;
        next_s.cs_act = 1'b0;
      end
    endcase
    if (enter_pre) begin
      if (s.cfg.pre_len != 5'h00) begin
        next_s.st = asdp_pkg::ST_PRE;
        next_s.cnt = s.cfg.pre_len - 5'h01;
        next_s.tx = s.cfg.pre_bits << (asdp_pkg::ASDP_PRE_FULL -
                                       s.cfg.pre_len);
      end else begin
        enter_hdr = 1'b1;
      end
    end
    if (enter_hdr) begin
      h = hdr_build(s.cfg, s.req);
      if (h[3:2] != 2'h0) begin
        next_s.st = asdp_pkg::ST_HDR;
        next_s.cnt = {3'h0, h[3:2] - 2'h1};
        next_s.tx = {h[1:0], 14'h0000};
      end else begin
        enter_data = 1'b1;
      end
    end
    if (enter_data) begin
      next_s.st = asdp_pkg::ST_DATA;
      next_s.cnt = {1'b0, s.cfg.wlen_m1};
      next_s.rx = 16'h0000;
      next_s.tx = s.req.read ? 16'h0000
                : wr_data << (asdp_pkg::ASDP_WORD_TOP - s.cfg.wlen_m1);
      next_s.wr_next = !s.req.read;
    end
    // pins follow the registered sequence state
    next_s.dout = next_s.tx[15];
    case (next_s.st)
      asdp_pkg::ST_PRE, asdp_pkg::ST_HDR: next_s.oe = 1'b1;
      // reads release the shared line in 3-wire style
      asdp_pkg::ST_DATA: next_s.oe = !next_s.req.read;
      default: next_s.oe = 1'b0;
    endcase
    if (next_s.st == asdp_pkg::ST_IDLE) begin
      next_s.dout = 1'b0;
    end
    next_s.cs_pins[0] = cs_level(next_s.cs_act && !next_s.req.disp,
                                 display_one_serial_config.cs_high);
    next_s.cs_pins[1] = cs_level(next_s.cs_act && next_s.req.disp,
                                 display_two_serial_config.cs_high);
    next_s.sclk_pin = next_s.sclk ^ next_s.cfg.clk_inv;
    next_s.req_ready = (next_s.st == asdp_pkg::ST_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
      s.cs_pins <= asdp_pkg::ASDP_CS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign req_ready = s.req_ready;
  assign wr_next = s.wr_next;
  assign rd_valid = s.rd_valid;
  assign rd_data = s.rd_data;
  assign done = s.done;
  assign serial_data_out = s.dout;
  assign serial_data_out_enable = s.oe;
  assign serial_display_clock = s.sclk_pin;
  assign display_chip_select = s.cs_pins;
  assign register_select_bit = s.rs_pin;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_cs_held;
    s.st inside {asdp_pkg::ST_PRE, asdp_pkg::ST_HDR, asdp_pkg::ST_DATA}
      |-> s.cs_act;
  endproperty
  a_cs_held: assert property (p_cs_held)
    else $error("chip select dropped inside a transfer");

  property p_cs_level;
    s.cs_act |-> display_chip_select[s.req.disp] == s.cfg.cs_high;
  endproperty
  a_cs_level: assert property (p_cs_level)
    else $error("chip select level wrong");

  property p_oe_read;
    s.st == asdp_pkg::ST_DATA && s.req.read
      |-> !serial_data_out_enable;
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("output enable on during read data");

  property p_oe_hdr;
    s.st inside {asdp_pkg::ST_PRE, asdp_pkg::ST_HDR}
      |-> serial_data_out_enable && serial_data_out == s.tx[15];
  endproperty
  a_oe_hdr: assert property (p_oe_hdr)
    else $error("header or preamble not driven");

  property p_pre_len;
    s.st == asdp_pkg::ST_SETUP && tick && s.cfg.pre_len != 5'h00
      |=> s.st == asdp_pkg::ST_PRE && s.cnt + 5'h01 == s.cfg.pre_len;
  endproperty
  a_pre_len: assert property (p_pre_len)
    else $error("preamble length wrong");

  property p_hdr_order;
    $rose(s.st == asdp_pkg::ST_HDR) && s.cfg.rw_en &&
      s.cfg.wiring inside {asdp_pkg::ASDP_W3, asdp_pkg::ASDP_W4}
      |-> s.cnt == 5'h01 &&
          s.tx[15] == (s.cfg.rw_first ? s.req.read : s.req.rs);
  endproperty
  a_hdr_order: assert property (p_hdr_order)
    else $error("header order wrong");

  property p_no_rw;
    $rose(s.st == asdp_pkg::ST_HDR) && !s.cfg.rw_en
      |-> s.cnt == 5'h00 && s.tx[15] == s.req.rs;
  endproperty
  a_no_rw: assert property (p_no_rw)
    else $error("direction bit not omitted");

  property p_burst;
    s.st == asdp_pkg::ST_DATA && tick && s.half && s.cnt == 5'h00 &&
      s.words != 8'h00
      |=> s.st == asdp_pkg::ST_DATA && s.words == $past(s.words) - 8'h01;
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst word not started");

  property p_cfg_pick;
    s.st == asdp_pkg::ST_IDLE && req_valid
      |=> s.cfg == ($past(req.disp) ? $past(display_two_serial_config)
                                    : $past(display_one_serial_config));
  endproperty
  a_cfg_pick: assert property (p_cfg_pick)
    else $error("wrong display configuration taken");

  property p_rs_type1;
    s.cfg.wiring == asdp_pkg::ASDP_W5T1 && s.cs_act
      |-> register_select_bit == s.req.rs;
  endproperty
  a_rs_type1: assert property (p_rs_type1)
    else $error("select line wrong at clock edge");

  property p_rs_type2;
    s.cfg.wiring == asdp_pkg::ASDP_W5T2 && s.cs_act
      |-> $stable(register_select_bit);
  endproperty
  a_rs_type2: assert property (p_rs_type2)
    else $error("select line moved under chip select");

  property p_cv_write;
    s.st == asdp_pkg::ST_DATA && !s.req.read ##[1:1000] done;
  endproperty
  c_cv_write: cover property (p_cv_write);

  property p_cv_rburst;
    rd_valid ##[1:1000] rd_valid;
  endproperty
  c_cv_rburst: cover property (p_cv_rburst);

  property p_cv_pre;
    s.st == asdp_pkg::ST_PRE ##[1:500] s.st == asdp_pkg::ST_HDR;
  endproperty
  c_cv_pre: cover property (p_cv_pre);
endmodule // asdp_serial_port

// ---- include/asdp_pkg.sv ----
// types and constants of the asynchronous serial display port
// assumes one system clock; configuration comes from software-held inputs
package asdp_pkg;

  // ==========================================================
  // widths and fixed values
  localparam int ASDP_WORD_W = 16;
  localparam int ASDP_PRE_W = 16;
  localparam logic [4:0] ASDP_PRE_FULL = 5'h10;
  localparam logic [3:0] ASDP_WORD_TOP = 4'hf;
  localparam logic ASDP_RW_READ = 1'h1;
  localparam logic [1:0] ASDP_CS_RESET = 2'h3;

  // ==========================================================
  // wiring styles, states, carriers
  typedef enum logic [1:0] {
    ASDP_W3, ASDP_W4, ASDP_W5T1, ASDP_W5T2
  } asdp_wiring_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_PRE, ST_HDR, ST_DATA, ST_END
  } asdp_state_t;

  // per-display link configuration
  typedef struct packed {
    asdp_wiring_t wiring;
    logic [4:0] pre_len;
    logic [ASDP_PRE_W-1:0] pre_bits;
    logic rw_en;
    logic rw_first;
    logic [3:0] wlen_m1;
    logic cs_high;
    logic clk_inv;
    logic [7:0] half_div;
  } asdp_cfg_t;

  // one transfer request
  typedef struct packed {
    logic disp;
    logic read;
    logic rs;
    logic [7:0] words_m1;
  } asdp_req_t;

  // divider state
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } asdp_div_t;

endpackage

// ---- testbench/asdp_panel.sv ----
// behavioural display panel on the serial command port
// assumes clock, select and data pins come from the port
`timescale 1ns/1ps
module asdp_panel (
  input wire logic sclk,
  input wire logic inv,
  input wire logic cs,
  input wire logic cs_high,
  input wire logic dout,
  input wire logic oe,
  input wire logic w3,
  input wire logic rsp,
  input wire logic rd_mode,
  input wire logic [7:0] hdr,
  input wire logic [31:0] pat,
  output logic act,
  output logic rs_cs,
  output logic rs_ok,
  output logic [63:0] got,
  output logic [7:0] n,
  output logic sdi
);
  // ==========================================================
  // select, sampling and answer
  logic pv = 1'h0;
  logic [31:0] sh;
  logic x;
  assign x = sclk ^ inv;
  assign act = (cs === cs_high);
  assign sdi = (w3 && oe) ? dout : pv;
  initial n = 8'h0;
  always @(posedge act) begin
    n = 8'h0;
    got = 64'h0;
    sh = pat;
    rs_cs = rsp;
    rs_ok = 1'h1;
  end
  // true clock rising edge samples data and the select line
  always @(posedge x) if (act) begin
    got = {got[62:0], w3 ? sdi : dout};
    n = n + 8'h1;
    if (rsp !== rs_cs) rs_ok = 1'h0;
  end
  always @(negedge x) if (act && rd_mode && n >= hdr) begin
    pv = sh[31];
    sh = sh << 1;
  end
  // a released line shows the inverse so a stale bit cannot pass
  always @(negedge act) pv = ~pv;
endmodule // asdp_panel

// ---- testbench/async_serial_display_port_tb_top.sv ----
// bench of the serial display port against a behavioural panel
// assumes the panel model and the port are compiled before it
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  n_mismatch++; $display("wrong value at %0t: %h vs %h", $time, a, b); \
  end end
module async_serial_display_port_tb_top;
  // ==========================================================
  // signals
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  logic req_valid = 1'h0;
  logic sdi, oe, dout, sclk, rsb, rdv, wrn, rdy, dn, act, rs_cs, rs_ok;
  logic pd = 1'h0;
  logic rdm = 1'h0;
  logic [7:0] hdr = 8'h0;
  logic [7:0] n;
  logic [31:0] pat = 32'h0;
  logic [63:0] got;
  logic [15:0] wd, rdd;
  logic [1:0] csb;
  logic [15:0] wq [2] = '{16'h0, 16'h0};
  logic [15:0] rq [2];
  asdp_pkg::asdp_cfg_t c1 = '0;
  asdp_pkg::asdp_cfg_t c2 = '0;
  asdp_pkg::asdp_req_t req = '0;
  int widx, ridx, n_mismatch, num_checks;
  assign wd = wq[widx & 1];
  always #2.5 sys_clk = ~sys_clk;
  // word indexes restart at the edge that takes a request
  always @(posedge sys_clk) begin
    if (req_valid && rdy) begin
      widx <= 0;
      ridx <= 0;
    end else begin
      if (wrn) widx <= widx + 1;
      if (rdv) begin
        rq[ridx & 1] <= rdd;
        ridx <= ridx + 1;
      end
    end
  end
  asdp_serial_port asdp_serial_port_inst (
    .sys_clk(sys_clk), .srst(srst),
    .display_one_serial_config(c1), .display_two_serial_config(c2),
    .req_valid(req_valid), .req(req), .req_ready(rdy), .wr_data(wd),
    .wr_next(wrn), .rd_valid(rdv), .rd_data(rdd), .done(dn),
    .serial_data_in(sdi), .serial_data_out(dout),
    .serial_data_out_enable(oe), .serial_display_clock(sclk),
    .display_chip_select(csb), .register_select_bit(rsb));
  asdp_panel asdp_panel_inst (
    .sclk(sclk), .inv(pd ? c2.clk_inv : c1.clk_inv), .cs(csb[pd]),
    .cs_high(pd ? c2.cs_high : c1.cs_high), .dout(dout), .oe(oe),
    .w3((pd ? c2.wiring : c1.wiring) == asdp_pkg::ASDP_W3), .rsp(rsb),
    .rd_mode(rdm), .hdr(hdr), .pat(pat), .act(act), .rs_cs(rs_cs),
    .rs_ok(rs_ok), .got(got), .n(n), .sdi(sdi));
  // ==========================================================
  // shared tasks
  task automatic set(input logic d, input asdp_pkg::asdp_cfg_t v);
    @(posedge sys_clk);
    if (d) c2 <= v;
    else c1 <= v;
  endtask
  // waits are bounded so a stuck handshake ends as a mismatch
  task automatic xfer(input logic d, rd, rs, input logic [7:0] m1);
    int k;
    @(posedge sys_clk);
    pd <= d;
    rdm <= rd;
    req_valid <= 1'h1;
    req <= '{d, rd, rs, m1};
    k = 0;
    do begin @(posedge sys_clk); k++; end while (rdy !== 1'h1 && k < 50);
    req_valid <= 1'h0;
    do begin @(posedge sys_clk); k++; end while (dn !== 1'h1 && k < 3000);
    `CHK(k < 3000, 1'h1)
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_write3;
    set(0, '{asdp_pkg::ASDP_W3, 5'h4, 16'h5, 1'h1, 1'h1, 4'h7, 1'h0,
      1'h0, 8'h7});
    wq[0] <= 16'h00a5;
    wq[1] <= 16'h003c;
    xfer(1'h0, 1'h0, 1'h1, 8'h1);
    `CHK(n, 8'h16)
    `CHK(got[21:0], {4'h5, 1'h0, 1'h1, 8'ha5, 8'h3c})
    `CHK(widx, 2)
  endtask
  task automatic t_order;
    set(0, '{asdp_pkg::ASDP_W3, 5'h0, 16'h0, 1'h1, 1'h0, 4'h3, 1'h0,
      1'h0, 8'h7});
    wq[0] <= 16'h0009;
    xfer(1'h0, 1'h0, 1'h1, 8'h0);
    `CHK(got[5:0], {1'h1, 1'h0, 4'h9})
    set(0, '{asdp_pkg::ASDP_W3, 5'h0, 16'h0, 1'h0, 1'h0, 4'h3, 1'h0,
      1'h0, 8'h7});
    xfer(1'h0, 1'h0, 1'h0, 8'h0);
    `CHK(n, 8'h5)
    `CHK(got[4:0], {1'h0, 4'h9})
  endtask
  task automatic t_read3;
    set(0, '{asdp_pkg::ASDP_W3, 5'h0, 16'h0, 1'h1, 1'h1, 4'hf, 1'h0,
      1'h0, 8'h7});
    hdr = 8'h2;
    pat = 32'hbeef0000;
    xfer(1'h0, 1'h1, 1'h0, 8'h0);
    `CHK(got[17:16], 2'h2)
    `CHK(got[15:0], 16'hbeef)
    `CHK(rq[0], 16'hbeef)
    `CHK(n, 8'h12)
    `CHK(oe, 1'h0)
  endtask
  task automatic t_w4d2;
    set(1, '{asdp_pkg::ASDP_W4, 5'h2, 16'h2, 1'h1, 1'h1, 4'h7, 1'h1,
      1'h1, 8'h7});
    hdr = 8'h4;
    pat = 32'h5ac30000;
    xfer(1'h1, 1'h1, 1'h1, 8'h1);
    `CHK(got[19:16], 4'hb)
    `CHK(rq[0], 16'h005a)
    `CHK(rq[1], 16'h00c3)
    `CHK(csb[0], 1'h1)
  endtask
  // five-wire styles carry the select on its own pin, not serially
  task automatic t_w5;
    for (int i = 0; i < 4; i++) begin
      set(0, '{i[1] ? asdp_pkg::ASDP_W5T2 : asdp_pkg::ASDP_W5T1, 5'h0,
        16'h0, 1'h1, 1'h1, 4'h7, 1'h0, 1'h0, 8'h7});
      wq[0] <= 16'h0081;
      xfer(1'h0, 1'h0, i[0], 8'h0);
      `CHK(got[8:0], {1'h0, 8'h81})
      `CHK(rs_cs, i[0])
      `CHK(rs_ok, 1'h1)
    end
  endtask
  // ==========================================================
  // run and verdict
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    t_write3();
    t_order();
    t_read3();
    t_w4d2();
    t_w5();
    results();
  end
endmodule // async_serial_display_port_tb_top
